// file: include/mcs_pkg.sv
/*
 * shared constants for the mac configuration and status block:
 * register offsets, field positions, reset values, frame limits,
 * management clock timing and the management shifter states.
 * assumes a 40 MHz system clock and a byte-addressed register port.
 */
package mcs_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MGMT = 8'h34;

  // configuration, control and status field positions
  localparam int CFG_IGNORE_CRC = 19;
  localparam int CFG_HDX_RX = 18;
  localparam int CFG_LEN_CHECK = 16;
  localparam int CFG_PAUSE_EN = 13;
  localparam int CFG_RETRY_TEST = 12;
  localparam int CFG_MDC_DIV_LO = 10;
  localparam int CFG_LONG_FRAME = 8;
  localparam int CFG_FULL_DUPLEX = 1;
  localparam int CFG_SPEED = 0;
  localparam int CTL_MGMT_EN = 4;
  localparam int STS_MGMT_IDLE = 2;

  // reset values and writable masks
  localparam logic [31:0] CFG_RESET = 32'h0000_0800;
  localparam logic [31:0] CFG_WMASK = 32'h000D_3D13;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_WMASK = 32'h0000_0010;
  localparam logic [31:0] STS_RESET = 32'h0000_0004;

  // frame limits in bytes
  localparam logic [15:0] MAX_STD_LEN = 16'h05EE;
  localparam logic [15:0] MAX_LONG_LEN = 16'h07D0;
  localparam logic [15:0] TYPE_ID_MIN = 16'h0600;

  // pause quantum and back-off
  localparam int PAUSE_BIT_TIMES = 512;
  localparam logic [9:0] ONE_SLOT = 10'h001;

  // management clock timing
  localparam int CLK_HZ = 40_000_000;
  localparam int MDC_MAX_HZ = 2_500_000;
  localparam int MDC_MIN_DIV = (CLK_HZ + MDC_MAX_HZ - 1) / MDC_MAX_HZ;
  localparam int MGMT_FRAME_W = 32;
  localparam int MGMT_DRIVE_BITS = 14;

  // interface modes
  localparam logic [1:0] IF_MII = 2'h0;

  // management shifter states, gray along idle -> shift -> done
  typedef enum logic [1:0] {
    MG_IDLE = 2'b00,
    MG_SHIFT = 2'b01,
    MG_DONE = 2'b11
  } mcs_mg_state_e;

endpackage

// file: logic/mcs_mac_config_and_status.sv
/*
 * mac configuration and status: register port, receive acceptance,
 * duplex and pause control, back-off selection, speed select and the
 * phy management port. assumes the mac core gives one-cycle pulses
 * on mclk; phy receive clock and mdio arrive from outside the domain.
 */
// Implementation choice: the address-and-strobe port.
// Overview of operation
// - ignore-checksum bit accepts bad-checksum frames and stops checksum error counting.
// - half-duplex receive bit allows reception while transmitting.
// - length checking discards frames shorter than their length field.
// - a type id in octets 13 and 14 is never a length error.
// - pause enable holds transmission after a valid pause frame.
// - retry test forces back-off of exactly one slot time.
// - retry test decrements pause counter every receive phy clock.
// - two-bit divider field, reset 0x2, divides system clock for management clock.
// - management clock never exceeds 2.5 MHz.
// - management clock toggles only during a management operation.
// - long-frame bit accepts frames up to 2000 bytes.
// - with long-frame clear, frames above 1518 bytes are rejected.
// - full duplex ignores collision and carrier sense, allows receive during transmit.
// - speed bit clear selects 10 Mbit/s, set selects 100 Mbit/s.
// - speed bit acts only on reduced-pin or serial interfaces.
// - idle status bit reads 1 when management idle, resets to 1.
// - configuration bits 31:20 read zero and ignore writes.
// - disabled management port releases data line and holds clock low.
module mcs_mac_config_and_status (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // phy pins
  input wire logic phy_rx_clk,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic mdc,
  // transmit side of mac core
  input wire logic tx_active,
  input wire logic collision_in,
  input wire logic carrier_in,
  input wire logic collision_pulse,
  input wire logic [3:0] attempt_cnt,
  input wire logic [9:0] backoff_rand,
  input wire logic slot_tick,
  output logic tx_collision_seen,
  output logic tx_carrier_seen,
  output logic tx_hold,
  output logic [9:0] backoff_slots_q,
  // receive side of mac core
  input wire logic frame_end,
  input wire logic [15:0] rx_len,
  input wire logic [15:0] len_field,
  input wire logic crc_bad,
  input wire logic pause_rx,
  input wire logic [15:0] pause_quanta,
  output logic rx_allowed,
  output logic rx_accept,
  output logic rx_reject,
  output logic crc_err_count,
  // interface mode and speed
  input wire logic [1:0] if_mode,
  output logic speed_100_q
);

  localparam logic [9:0] BIT_TICKS_10 = 10'(mcs_pkg::PAUSE_BIT_TIMES - 1);

  //////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] cfg_q;
  logic [31:0] ctl_q;
  logic [31:0] mgmt_frame_q;
  logic mgmt_start_q;
  logic mgmt_busy;
  logic mgmt_done;
  logic [15:0] mgmt_rd;

  // decode used by both writes and reads
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // configuration, only writable fields change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= mcs_pkg::CFG_RESET;
    end else if (reg_wr && hit(reg_addr, mcs_pkg::OFF_CONFIG)) begin
      cfg_q <= reg_wdata & mcs_pkg::CFG_WMASK;
    end
  end

  // control, management port enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= mcs_pkg::CTL_RESET;
    end else if (reg_wr && hit(reg_addr, mcs_pkg::OFF_CONTROL)) begin
      ctl_q <= reg_wdata & mcs_pkg::CTL_WMASK;
    end
  end

  // management frame, a write starts an operation when idle and the port is enabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_frame_q <= 32'h0000_0000;
      mgmt_start_q <= 1'b0;
    end else begin
      mgmt_start_q <= 1'b0;
      if (reg_wr && hit(reg_addr, mcs_pkg::OFF_MGMT) && !mgmt_busy && !mgmt_start_q) begin
        mgmt_frame_q <= reg_wdata;
        mgmt_start_q <= ctl_q[mcs_pkg::CTL_MGMT_EN];
      end
    end
  end

  // read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (hit(reg_addr, mcs_pkg::OFF_CONFIG)) begin
        reg_rdata <= cfg_q;
      end else if (hit(reg_addr, mcs_pkg::OFF_CONTROL)) begin
        reg_rdata <= ctl_q;
      end else if (hit(reg_addr, mcs_pkg::OFF_STATUS)) begin
        reg_rdata <= {29'h0000_0000, !mgmt_busy && !mgmt_start_q, 2'h0};
      end else if (hit(reg_addr, mcs_pkg::OFF_MGMT)) begin
        reg_rdata <= {mgmt_frame_q[31:16], mgmt_rd};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // phy management port

  logic mdio_s1_q;
  logic mdio_s2_q;

  // two-stage synchroniser for the data line
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mdio_s1_q <= 1'b0;
      mdio_s2_q <= 1'b0;
    end else begin
      mdio_s1_q <= mdio_in;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  // shifter, divider field picks the clock ratio
  mcs_mgmt_shift u_mgmt (
    .mclk(mclk),
    .rst_n(rst_n),
    .port_en(ctl_q[mcs_pkg::CTL_MGMT_EN]),
    .div_sel(cfg_q[mcs_pkg::CFG_MDC_DIV_LO +: 2]),
    .start(mgmt_start_q),
    .frame(mgmt_frame_q),
    .mdio_in(mdio_s2_q),
    .mdio_o(mdio_out),
    .mdio_oe(mdio_oe),
    .mdc(mdc),
    .busy(mgmt_busy),
    .done(mgmt_done),
    .rd_data(mgmt_rd)
  );

  //////////////////////////////////////////////////////////////////////
  // receive acceptance

  mcs_rx_check u_rx (
    .mclk(mclk),
    .rst_n(rst_n),
    .ignore_bad_checksum(cfg_q[mcs_pkg::CFG_IGNORE_CRC]),
    .len_check_en(cfg_q[mcs_pkg::CFG_LEN_CHECK]),
    .long_frame_en(cfg_q[mcs_pkg::CFG_LONG_FRAME]),
    .frame_end(frame_end),
    .rx_len(rx_len),
    .len_field(len_field),
    .crc_bad(crc_bad),
    .accept_q(rx_accept),
    .reject_q(rx_reject),
    .crc_count_q(crc_err_count)
  );

  //////////////////////////////////////////////////////////////////////
  // duplex and speed

  logic full_dup;
  assign full_dup = cfg_q[mcs_pkg::CFG_FULL_DUPLEX];

  // receive gate and transmit line sensing
  assign rx_allowed = !tx_active || full_dup || cfg_q[mcs_pkg::CFG_HDX_RX];
  assign tx_collision_seen = collision_in && !full_dup;
  assign tx_carrier_seen = carrier_in && !full_dup;

  // speed select, plain mii always runs at the pins' own rate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      speed_100_q <= 1'b0;
    end else begin
      speed_100_q <= cfg_q[mcs_pkg::CFG_SPEED] && if_mode != mcs_pkg::IF_MII;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // back-off and pause

  logic rxc_s1_q;
  logic rxc_s2_q;
  logic rxc_s3_q;
  logic rxc_rise;
  logic [9:0] bit_cnt_q;
  logic quantum_tick;
  logic [15:0] pause_q;
  logic retry_test;

  assign retry_test = cfg_q[mcs_pkg::CFG_RETRY_TEST];

  // back-off window, truncated exponential unless under test
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      backoff_slots_q <= 10'h000;
    end else if (collision_pulse) begin
      if (retry_test) begin
        backoff_slots_q <= mcs_pkg::ONE_SLOT;
      end else begin
        backoff_slots_q <= backoff_rand & 10'((11'h001 << attempt_cnt) - 11'h001);
      end
    end
  end

  // receive phy clock synchroniser, edge taken after stage two
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxc_s1_q <= 1'b0;
      rxc_s2_q <= 1'b0;
      rxc_s3_q <= 1'b0;
    end else begin
      rxc_s1_q <= phy_rx_clk;
      rxc_s2_q <= rxc_s1_q;
      rxc_s3_q <= rxc_s2_q;
    end
  end
  assign rxc_rise = rxc_s2_q && !rxc_s3_q;

  // pause quantum: 512 bit times, or every receive clock under test
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 10'h000;
    end else if (slot_tick) begin
      bit_cnt_q <= (bit_cnt_q == BIT_TICKS_10) ? 10'h000 : bit_cnt_q + 10'h001;
    end
  end
  assign quantum_tick = retry_test ? rxc_rise : (slot_tick && bit_cnt_q == BIT_TICKS_10);

  // pause counter, reload wins over decrement
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pause_q <= 16'h0000;
    end else if (pause_rx && cfg_q[mcs_pkg::CFG_PAUSE_EN]) begin
      pause_q <= pause_quanta;
    end else if (quantum_tick && pause_q != 16'h0000) begin
      pause_q <= pause_q - 16'h0001;
    end
  end
  assign tx_hold = cfg_q[mcs_pkg::CFG_PAUSE_EN] && pause_q != 16'h0000;

  //////////////////////////////////////////////////////////////////////
  // checks

  sequence s_mgmt_start;
    mgmt_start_q;
  endsequence

  sequence s_mgmt_finish;
    mgmt_done ##1 !mgmt_busy;
  endsequence

  chk_cfg_upper_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_q[31:20] == 12'h000)
    else $error("configuration upper bits not zero");

  chk_status_idle_read: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && hit(reg_addr, mcs_pkg::OFF_STATUS) && !mgmt_busy && !mgmt_start_q
    |=> reg_rdata == mcs_pkg::STS_RESET)
    else $error("idle status bit wrong");

  // helper: cycles spent in one management operation, saturating
  logic [11:0] mgmt_age_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_age_q <= 12'h000;
    end else if (!mgmt_busy) begin
      mgmt_age_q <= 12'h000;
    end else if (mgmt_age_q != 12'hFFF) begin
      mgmt_age_q <= mgmt_age_q + 12'h001;
    end
  end

  chk_idle_drop_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    s_mgmt_start |=> mgmt_busy)
    else $error("management operation did not start");

  chk_idle_return: assert property (@(posedge mclk) disable iff (!rst_n)
    mgmt_done |-> s_mgmt_finish)
    else $error("management logic not idle after frame");

  chk_mgmt_bounded: assert property (@(posedge mclk) disable iff (!rst_n)
    mgmt_age_q != 12'hFFF)
    else $error("management operation did not complete");

  chk_mdc_idle_low: assert property (@(posedge mclk) disable iff (!rst_n)
    !mgmt_busy |-> !mdc)
    else $error("management clock active while idle");

  chk_mdc_min_half: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(mdc) |-> mdc [*8])
    else $error("management clock faster than allowed");

  chk_port_disabled: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctl_q[mcs_pkg::CTL_MGMT_EN] |=> !mdio_oe && !mdc)
    else $error("disabled port still drives");

  chk_backoff_test: assert property (@(posedge mclk) disable iff (!rst_n)
    collision_pulse && retry_test |=> backoff_slots_q == mcs_pkg::ONE_SLOT)
    else $error("test back-off not one slot");

  chk_pause_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    pause_rx && cfg_q[mcs_pkg::CFG_PAUSE_EN] && pause_quanta != 16'h0000 |=> tx_hold)
    else $error("pause frame did not hold transmit");

  chk_pause_fast: assert property (@(posedge mclk) disable iff (!rst_n)
    retry_test && rxc_rise && !pause_rx && pause_q != 16'h0000
    |=> pause_q == $past(pause_q) - 16'h0001)
    else $error("pause counter missed receive clock");

  chk_crc_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
    frame_end && cfg_q[mcs_pkg::CFG_IGNORE_CRC] |=> !crc_err_count)
    else $error("checksum error counted while ignored");

  chk_long_reject: assert property (@(posedge mclk) disable iff (!rst_n)
    frame_end && !cfg_q[mcs_pkg::CFG_LONG_FRAME] && rx_len > mcs_pkg::MAX_STD_LEN |=> rx_reject)
    else $error("oversize frame accepted");

  chk_fdx_sense: assert property (@(posedge mclk) disable iff (!rst_n)
    full_dup |-> !tx_collision_seen && !tx_carrier_seen && rx_allowed)
    else $error("full duplex still senses line");

endmodule

// file: logic/mcs_mgmt_shift.sv
/*
 * management frame shifter: divides the system clock down to the
 * management clock and shifts one frame out and back in.
 * assumes mdio_in is already synchronised to mclk.
 */
module mcs_mgmt_shift #(
  parameter int FRAME_W = mcs_pkg::MGMT_FRAME_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic port_en,
  input wire logic [1:0] div_sel,
  input wire logic start,
  input wire logic [31:0] frame,
  // pins
  input wire logic mdio_in,
  output logic mdio_o,
  output logic mdio_oe,
  output logic mdc,
  // status
  output logic busy,
  output logic done,
  output logic [15:0] rd_data
);

  localparam logic [7:0] HALF_BASE = 8'(mcs_pkg::MDC_MIN_DIV / 2);

  // elaboration check: shifter and turnaround assume 32-bit frames
  if (FRAME_W != 32) begin : g_bad_frame_w
    $error("frame width must be 32");
  end

  mcs_pkg::mcs_mg_state_e st_q;
  logic [7:0] cnt_q;
  logic [7:0] half_cnt;
  logic tick;
  logic mdc_q;
  logic [4:0] bit_q;
  logic [31:0] sh_q;
  logic [31:0] rx_q;
  logic is_read_q;

  // half period grows with the divider selection
  assign half_cnt = 8'(HALF_BASE * ({6'h00, div_sel} + 8'h01));
  assign tick = (cnt_q == half_cnt - 8'h01);

  // divider runs only while shifting
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (st_q != mcs_pkg::MG_SHIFT || tick) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // frame sequencing, clock toggles only inside a frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= mcs_pkg::MG_IDLE;
      mdc_q <= 1'b0;
      bit_q <= 5'h00;
      sh_q <= 32'h0000_0000;
      rx_q <= 32'h0000_0000;
      is_read_q <= 1'b0;
    end else if (!port_en) begin
      st_q <= mcs_pkg::MG_IDLE;
      mdc_q <= 1'b0;
    end else begin
      case (st_q)
        mcs_pkg::MG_IDLE: begin
          if (start) begin
            st_q <= mcs_pkg::MG_SHIFT;
            sh_q <= frame;
            bit_q <= 5'h00;
            is_read_q <= (frame[29:28] == 2'b10);
          end
        end
        mcs_pkg::MG_SHIFT: begin
          if (tick && !mdc_q) begin
            mdc_q <= 1'b1;
            rx_q <= {rx_q[30:0], mdio_in};
          end else if (tick) begin
            mdc_q <= 1'b0;
            sh_q <= {sh_q[30:0], 1'b0};
            if (bit_q == 5'(FRAME_W - 1)) begin
              st_q <= mcs_pkg::MG_DONE;
            end else begin
              bit_q <= bit_q + 5'h01;
            end
          end
        end
        mcs_pkg::MG_DONE: begin
          st_q <= mcs_pkg::MG_IDLE;
        end
        default: begin
          st_q <= mcs_pkg::MG_IDLE;
        end
      endcase
    end
  end

  // outputs, data released from the first turnaround bit on reads
  assign mdc = mdc_q;
  assign mdio_o = sh_q[31];
  assign mdio_oe = port_en && st_q == mcs_pkg::MG_SHIFT
                   && (!is_read_q || bit_q < 5'(mcs_pkg::MGMT_DRIVE_BITS));
  assign busy = st_q != mcs_pkg::MG_IDLE;
  assign done = st_q == mcs_pkg::MG_DONE;
  assign rd_data = rx_q[15:0];

endmodule

// file: logic/mcs_rx_check.sv
/*
 * receive frame acceptance: length, length field and checksum tests
 * at the end of each frame. assumes frame_end is a one-cycle pulse
 * on mclk with the frame figures valid beside it.
 */
module mcs_rx_check (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // configuration
  input wire logic ignore_bad_checksum,
  input wire logic len_check_en,
  input wire logic long_frame_en,
  // frame figures
  input wire logic frame_end,
  input wire logic [15:0] rx_len,
  input wire logic [15:0] len_field,
  input wire logic crc_bad,
  // verdicts
  output logic accept_q,
  output logic reject_q,
  output logic crc_count_q
);

  logic too_long;
  logic len_short;
  logic crc_fail;
  logic bad;

  // length limit, field test skipped for type ids
  assign too_long = rx_len > (long_frame_en ? mcs_pkg::MAX_LONG_LEN : mcs_pkg::MAX_STD_LEN);
  assign len_short = len_check_en && len_field < mcs_pkg::TYPE_ID_MIN
                     && rx_len < len_field;
  assign crc_fail = crc_bad && !ignore_bad_checksum;
  assign bad = too_long || len_short || crc_fail;

  // one-cycle verdict after each frame end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      accept_q <= 1'b0;
      reject_q <= 1'b0;
      crc_count_q <= 1'b0;
    end else begin
      accept_q <= frame_end && !bad;
      reject_q <= frame_end && bad;
      crc_count_q <= frame_end && crc_fail;
    end
  end

endmodule

// file: verif/mcs_phy_model.sv
/*
 * phy model for the far side of the mac: free-running receive clock
 * and a management responder that answers read frames.
 * assumes the bench resolves the data line with a pull-up.
 */
module mcs_phy_model #(
  parameter logic [15:0] READ_WORD = 16'hC35A
) (
  // management pins
  input wire logic mdc,
  input wire logic mdio_oe,
  output logic phy_oe,
  output logic phy_do,
  // receive clock
  output logic phy_rx_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  logic [16:0] sh;
  initial begin
    phy_rx_clk = 1'b0;
    phy_oe = 1'b0;
    phy_do = 1'b0;
    cnt = 0;
    sh = 17'h0_0000;
  end
  // receive clock, 25 MHz, unrelated to mclk
  always #20 phy_rx_clk = ~phy_rx_clk;
  // new frame from the mac: release the line
  always @(posedge mdio_oe) begin
    phy_oe = 1'b0;
    cnt = 0;
    sh = {1'b0, READ_WORD};
  end
  // turnaround zero then data msb first, changed on mdc fall
  always @(negedge mdc) begin
    #1;
    if (!mdio_oe) begin
      cnt++;
      // first released bit stays undriven, then zero and 16 data bits
      phy_oe = (cnt >= 2 && cnt <= 18);
      if (cnt >= 2) begin
        phy_do = sh[16];
        sh = {sh[15:0], 1'b1};
      end
    end
  end
endmodule

// file: verif/testbench.sv
/*
 * self-checking bench for the mac configuration and status block.
 * assumes the phy model on the management pins and a 40 MHz clock.
 */
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, tx_active = 0;
  logic collision_in = 0, carrier_in = 0, collision_pulse = 0, slot_tick = 0;
  logic frame_end = 0, crc_bad = 0, pause_rx = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rd;
  logic [3:0] attempt_cnt = 4'h0;
  logic [9:0] backoff_rand = 10'h000, backoff_slots_q;
  logic [15:0] rx_len = 16'h0000, len_field = 16'h0000, pause_quanta = 16'h0000;
  logic [1:0] if_mode = 2'h0;
  logic phy_rx_clk, mdio_out, mdio_oe, mdc, phy_oe, phy_do, mdio_line;
  logic tx_collision_seen, tx_carrier_seen, tx_hold, rx_allowed, rx_accept, rx_reject;
  logic crc_err_count, speed_100_q;
  int mismatches = 0, n_checks = 0, hi;
  // data line with pull-up
  assign mdio_line = mdio_oe ? mdio_out : (phy_oe ? phy_do : 1'b1);
  always #12.5 mclk = ~mclk;
  mcs_mac_config_and_status dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .phy_rx_clk(phy_rx_clk), .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .mdc(mdc), .tx_active(tx_active), .collision_in(collision_in), .carrier_in(carrier_in),
    .collision_pulse(collision_pulse), .attempt_cnt(attempt_cnt),
    .backoff_rand(backoff_rand), .slot_tick(slot_tick),
    .tx_collision_seen(tx_collision_seen), .tx_carrier_seen(tx_carrier_seen),
    .tx_hold(tx_hold), .backoff_slots_q(backoff_slots_q), .frame_end(frame_end),
    .rx_len(rx_len), .len_field(len_field), .crc_bad(crc_bad), .pause_rx(pause_rx),
    .pause_quanta(pause_quanta), .rx_allowed(rx_allowed), .rx_accept(rx_accept),
    .rx_reject(rx_reject), .crc_err_count(crc_err_count), .if_mode(if_mode),
    .speed_100_q(speed_100_q));
  mcs_phy_model phy (.mdc(mdc), .mdio_oe(mdio_oe), .phy_oe(phy_oe), .phy_do(phy_do),
    .phy_rx_clk(phy_rx_clk));
  ////////////////////////////////////////////////////////////////////////////////
  // register port accesses
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // one received frame and its verdict
  task automatic frm(input logic [15:0] l, f, input logic b, acc, cnt);
    @(posedge mclk);
    frame_end <= 1'b1;
    rx_len <= l;
    len_field <= f;
    crc_bad <= b;
    @(posedge mclk);
    frame_end <= 1'b0;
    #1 `CHK("accept", acc, rx_accept)
    `CHK("reject", !acc, rx_reject)
    `CHK("crc count", cnt, crc_err_count)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    finish_test;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values and access kinds
    rdr(mcs_pkg::OFF_CONFIG); `CHK("cfg reset", 32'h0000_0800, rd)
    rdr(mcs_pkg::OFF_STATUS); `CHK("sts reset", 32'h0000_0004, rd)
    wr(mcs_pkg::OFF_STATUS, 32'h0000_0000);
    rdr(mcs_pkg::OFF_STATUS); `CHK("sts ro", 32'h0000_0004, rd)
    wr(mcs_pkg::OFF_CONFIG, 32'hFFFF_FFFF);
    rdr(mcs_pkg::OFF_CONFIG); `CHK("cfg mask", 32'h000D_3D13, rd)
    wr(8'h10, 32'h0000_0000);
    rdr(8'h10); `CHK("unmapped", 32'h0000_0000, rd)
    // frame acceptance, default limits
    wr(mcs_pkg::OFF_CONFIG, 32'h0000_0800);
    frm(16'd1518, 16'h0800, 1'b0, 1'b1, 1'b0);
    frm(16'd1519, 16'h0800, 1'b0, 1'b0, 1'b0);
    frm(16'd100, 16'h0800, 1'b1, 1'b0, 1'b1);
    frm(16'd60, 16'd100, 1'b0, 1'b1, 1'b0);
    // checksum ignored, long frames, length field checking
    wr(mcs_pkg::OFF_CONFIG, 32'h0009_0900);
    frm(16'd100, 16'h0800, 1'b1, 1'b1, 1'b0);
    frm(16'd2000, 16'h0800, 1'b0, 1'b1, 1'b0);
    frm(16'd2001, 16'h0800, 1'b0, 1'b0, 1'b0);
    frm(16'd60, 16'd100, 1'b0, 1'b0, 1'b0);
    frm(16'd60, 16'h0600, 1'b0, 1'b1, 1'b0);
    // duplex gating of line sense and reception
    collision_in <= 1'b1;
    carrier_in <= 1'b1;
    tx_active <= 1'b1;
    wr(mcs_pkg::OFF_CONFIG, 32'h0000_0800);
    #1 `CHK("col hdx", 1'b1, tx_collision_seen)
    `CHK("rx hdx", 1'b0, rx_allowed)
    wr(mcs_pkg::OFF_CONFIG, 32'h0004_0800);
    #1 `CHK("rx hdx en", 1'b1, rx_allowed)
    wr(mcs_pkg::OFF_CONFIG, 32'h0000_0803);
    #1 `CHK("col fdx", 1'b0, tx_collision_seen)
    `CHK("crs fdx", 1'b0, tx_carrier_seen)
    `CHK("rx fdx", 1'b1, rx_allowed)
    // speed select only on reduced-pin interfaces
    repeat (3) @(posedge mclk);
    #1 `CHK("speed mii", 1'b0, speed_100_q)
    if_mode <= 2'h1;
    repeat (3) @(posedge mclk);
    #1 `CHK("speed 100", 1'b1, speed_100_q)
    wr(mcs_pkg::OFF_CONFIG, 32'h0000_0802);
    repeat (3) @(posedge mclk);
    #1 `CHK("speed 10", 1'b0, speed_100_q)
    // back-off after a collision, normal then retry test
    attempt_cnt <= 4'h3;
    backoff_rand <= 10'h3FF;
    for (int i = 0; i < 2; i++) begin
      wr(mcs_pkg::OFF_CONFIG, i ? 32'h0000_1800 : 32'h0000_0800);
      @(posedge mclk);
      collision_pulse <= 1'b1;
      @(posedge mclk);
      collision_pulse <= 1'b0;
      @(posedge mclk);
      #1 `CHK("backoff", i ? mcs_pkg::ONE_SLOT : 10'h007, backoff_slots_q)
    end
    // pause: ignored when disabled, held until retry test speeds the count
    for (int i = 0; i < 2; i++) begin
      wr(mcs_pkg::OFF_CONFIG, i ? 32'h0000_2800 : 32'h0000_0800);
      @(posedge mclk);
      pause_rx <= 1'b1;
      pause_quanta <= 16'h0002;
      @(posedge mclk);
      pause_rx <= 1'b0;
      repeat (40) @(posedge mclk);
      #1 `CHK("pause hold", i[0], tx_hold)
    end
    wr(mcs_pkg::OFF_CONFIG, 32'h0000_3800);
    repeat (20) @(posedge mclk);
    #1 `CHK("pause fast", 1'b0, tx_hold)
    // management read frame
    wr(mcs_pkg::OFF_CONFIG, 32'h0000_0800);
    wr(mcs_pkg::OFF_CONTROL, 32'h0000_0010);
    wr(mcs_pkg::OFF_MGMT, 32'h6000_0000);
    rdr(mcs_pkg::OFF_STATUS); `CHK("busy", 32'h0000_0000, rd)
    hi = 0;
    for (int i = 0; i < 200 && !mdc; i++) begin
      @(posedge mclk);
      #1;
    end
    for (int i = 0; i < 200 && mdc; i++) begin
      @(posedge mclk);
      #1 hi++;
    end
    `CHK("mdio bit1", 2'b11, {mdio_oe, mdio_out})
    `CHK("mdc half", 24, hi)
    `CHK("mdc max", 1'b1, hi >= mcs_pkg::MDC_MIN_DIV / 2)
    rd = 32'h0000_0000;
    for (int i = 0; i < 100 && rd[2] !== 1'b1; i++) begin
      repeat (40) @(posedge mclk);
      rdr(mcs_pkg::OFF_STATUS);
    end
    `CHK("idle again", 32'h0000_0004, rd)
    `CHK("mdc idle", 1'b0, mdc)
    rdr(mcs_pkg::OFF_MGMT); `CHK("read word", 16'hC35A, rd[15:0])
    // disabled port: no frame, line released, clock low
    wr(mcs_pkg::OFF_CONTROL, 32'h0000_0000);
    wr(mcs_pkg::OFF_MGMT, 32'h5000_0000);
    hi = 0;
    repeat (100) begin
      @(posedge mclk);
      #1 hi += mdc + mdio_oe;
    end
    `CHK("disabled pins", 0, hi)
    rdr(mcs_pkg::OFF_STATUS); `CHK("disabled idle", 32'h0000_0004, rd)
    finish_test;
  end
endmodule
